/* File: hw/crm_core_regs.sv */
// Purpose: Programmer-visible register model of a 16-bit processor core.
// Assumes: Operation port driven by same-clock core logic.
// Notes:   Register port reads answer one cycle after the strobe.
module crm_core_regs
    import crm_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Reset vector contents.
    input  wire logic [15:0] rv_ptr3,
    input  wire logic [3:0]  rv_ptr3_bank,
    input  wire logic [15:0] rv_pc,
    input  wire logic [15:0] rv_sp,
    input  wire logic [3:0]  rv_stack_bank,
    // Core operation port.
    input  wire logic [2:0]  op,
    input  wire logic        op_byte,
    input  wire logic [15:0] op_a,
    input  wire logic [15:0] op_b,
    input  wire logic        op_sub,
    input  wire logic [35:0] mac_in,
    input  wire logic [3:0]  irq_level,
    // Register port.
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Results.
    output logic      [23:0] bus_addr,
    output logic             clock_stopped,
    output logic             irq_accept,
    output logic             misaligned,
    output logic      [15:0] sat_out
);

    logic [15:0] acc_d_reg;
    logic [15:0] acc_e_reg;
    logic [15:0] ptr_reg [3];
    logic [3:0]  pbank_reg [3];
    logic [15:0] sp_reg;
    logic [3:0]  stack_bank_reg;
    logic [15:0] pc_reg;
    logic [15:0] ccr_reg;
    logic [35:0] am_reg;
    logic        sat_sign_reg;
    logic [19:0] addr_next;
    logic [16:0] sum;
    logic [19:0] step;
    logic [19:0] stk;
    logic        ovf;
    logic [36:0] am_next;
    logic [15:0] flag_src;
    crm_addr_if  aif();

    // Concatenates a bank field above a 16-bit register value.
    function automatic logic [19:0] join_addr(input logic [3:0] bk,
                                              input logic [15:0] v);
        join_addr = {bk, v};
    endfunction

    assign stk = join_addr(stack_bank_reg, sp_reg);
    assign sum = op_sub ? {1'b0, op_a} - {1'b0, op_b}
                        : {1'b0, op_a} + {1'b0, op_b};
    assign step = op_byte ? 20'h00001 : 20'h00002;
    assign ovf = op_sub ? (op_a[15] != op_b[15]) && (sum[15] != op_a[15])
                        : (op_a[15] == op_b[15]) && (sum[15] != op_a[15]);
    assign am_next = {am_reg[35], am_reg} + {mac_in[35], mac_in};
    assign flag_src = (op == OP_ALU) ? sum[15:0] : op_a;

    crm_bus_widen u_widen
    (
        .a (aif.widen)
    );

    function automatic logic [3:0] pc_reg_bank(input logic [15:0] cc);
        pc_reg_bank = cc[3:0];
    endfunction

    always_comb
    begin
        case (op)
            OP_FETCH: addr_next = {pc_reg_bank(ccr_reg), pc_reg[15:1],
                                   1'b0};
            OP_PUSH:  addr_next = stk;
            OP_PULL:  addr_next = stk + 20'h00001;
            default:  addr_next = join_addr(pbank_reg[0], ptr_reg[0]);
        endcase
    end
    assign aif.core_addr = addr_next;

    // The vector is taken on the first enabled cycle after reset, so the
    // third pointer can serve as a direct page pointer at once.
    logic load_vec_reg;
    always_ff @(posedge clock)
    begin
        if (rst)
            load_vec_reg <= 1'b1;
        else if (clk_en)
            load_vec_reg <= 1'b0;
    end

    // Accumulators and pointers.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            acc_d_reg <= 16'h0000;
            acc_e_reg <= 16'h0000;
            for (int i = 0; i < 3; i++)
            begin
                ptr_reg[i]   <= 16'h0000;
                pbank_reg[i] <= 4'h0;
            end
        end
        else if (clk_en)
        begin
            if (op == OP_ALU)
                acc_d_reg <= sum[15:0];
            if (reg_wr)
            begin
                case (reg_addr)
                    OFF_ACC_D: acc_d_reg <= reg_wdata;
                    OFF_ACC_E: acc_e_reg <= reg_wdata;
                    OFF_PTR1:  ptr_reg[0] <= reg_wdata;
                    OFF_PTR2:  ptr_reg[1] <= reg_wdata;
                    OFF_PTR3:  ptr_reg[2] <= reg_wdata;
                    OFF_BANKS:
                    begin
                        pbank_reg[0] <= reg_wdata[3:0];
                        pbank_reg[1] <= reg_wdata[7:4];
                        pbank_reg[2] <= reg_wdata[11:8];
                    end
                    default: ;
                endcase
            end
            if (load_vec_reg)
            begin
                ptr_reg[2]   <= rv_ptr3;
                pbank_reg[2] <= rv_ptr3_bank;
            end
        end
    end

    // Stack and program counter.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sp_reg         <= 16'h0000;
            stack_bank_reg <= 4'h0;
            pc_reg         <= 16'h0000;
        end
        else if (clk_en)
        begin
            if (load_vec_reg)
            begin
                sp_reg         <= rv_sp;
                stack_bank_reg <= rv_stack_bank;
                pc_reg         <= rv_pc;
            end
            else if (op == OP_PUSH)
                {stack_bank_reg, sp_reg} <= stk - step;
            else if (op == OP_PULL)
                {stack_bank_reg, sp_reg} <= stk + step;
            else if (op == OP_FETCH)
                pc_reg <= {pc_reg[15:1], 1'b0} + 16'h0002;
            else if (reg_wr && reg_addr == OFF_STACK)
                sp_reg <= reg_wdata;
            else if (reg_wr && reg_addr == OFF_STBANK)
                stack_bank_reg <= reg_wdata[3:0];
            else if (reg_wr && reg_addr == OFF_PROG)
                pc_reg <= reg_wdata;
        end
    end

    // Condition codes and product accumulator.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ccr_reg      <= CCR_RESET;
            am_reg       <= 36'h000000000;
            sat_sign_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            case (op)
                OP_ALU:
                begin
                    ccr_reg[CC_V] <= ovf;
                    ccr_reg[CC_C] <= sum[16];
                    ccr_reg[CC_N] <= flag_src[15];
                    ccr_reg[CC_Z] <= (flag_src == 16'h0000);
                end
                OP_BCD:
                    ccr_reg[CC_H] <= (op_a[3:0] + op_b[3:0]) > 5'h0f;
                OP_MAC:
                begin
                    am_reg <= am_next[35:0];
                    if (am_next[36] != am_next[35])
                        ccr_reg[CC_MV] <= 1'b1;
                    if (am_next[35:31] != {5{am_next[31]}})
                        ccr_reg[CC_EV] <= 1'b1;
                    // The true sign is frozen once the overflow flag is up.
                    if (!ccr_reg[CC_MV])
                        sat_sign_reg <= am_next[36];
                end
                // A pulled operand is a read, so N and Z follow it.
                OP_PULL:
                begin
                    ccr_reg[CC_N] <= op_a[15];
                    ccr_reg[CC_Z] <= (op_a == 16'h0000);
                end
                default: ;
            endcase
            if (reg_wr && reg_addr == OFF_CCR)
                ccr_reg <= reg_wdata;
        end
    end

    // Outputs.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bus_addr      <= 24'h000000;
            clock_stopped <= 1'b0;
            irq_accept    <= 1'b0;
            misaligned    <= 1'b0;
            sat_out       <= 16'h0000;
        end
        else if (clk_en)
        begin
            bus_addr <= aif.bus_addr;
            if (op == OP_STOP && !ccr_reg[CC_STOP])
                clock_stopped <= 1'b1;
            else if (irq_accept)
                clock_stopped <= 1'b0;
            irq_accept <= (irq_level == 4'h7) ||
                          ({1'b0, ccr_reg[CC_IPH:CC_IPL]} < irq_level);
            misaligned <= (op == OP_PUSH || op == OP_PULL) && !op_byte
                          && sp_reg[0];
            if (ccr_reg[CC_SM] && (ccr_reg[CC_EV] || ccr_reg[CC_MV]))
                sat_out <= sat_sign_reg ? 16'h8000 : 16'h7fff;
            else
                sat_out <= am_reg[AM_EXT:16];
        end
    end

    // Register port read, answered one cycle later.
    always_ff @(posedge clock)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (clk_en && reg_rd)
        begin
            case (reg_addr)
                OFF_ACC_D:  reg_rdata <= acc_d_reg;
                OFF_ACC_E:  reg_rdata <= acc_e_reg;
                OFF_PTR1:   reg_rdata <= ptr_reg[0];
                OFF_PTR2:   reg_rdata <= ptr_reg[1];
                OFF_PTR3:   reg_rdata <= ptr_reg[2];
                OFF_STACK:  reg_rdata <= sp_reg;
                OFF_PROG:   reg_rdata <= pc_reg;
                OFF_CCR:    reg_rdata <= ccr_reg;
                OFF_BANKS:  reg_rdata <= {4'h0, pbank_reg[2], pbank_reg[1],
                                          pbank_reg[0]};
                OFF_STATUS: reg_rdata <= {13'h0, misaligned,
                                          irq_accept, clock_stopped};
                OFF_STBANK: reg_rdata <= {12'h000, stack_bank_reg};
                default:    reg_rdata <= 16'h0000;
            endcase
        end
    end

    a_push_dec: assert property (@(posedge clock) disable iff (rst)
        clk_en && !load_vec_reg && op == OP_PUSH && !op_byte
        |=> {stack_bank_reg, sp_reg} == $past(stk) - 20'h2)
        else $error("push did not step stack down");
    a_pull_inc: assert property (@(posedge clock) disable iff (rst)
        clk_en && !load_vec_reg && op == OP_PULL && op_byte
        |=> {stack_bank_reg, sp_reg} == $past(stk) + 20'h1)
        else $error("pull did not step stack up");
    a_fetch_align: assert property (@(posedge clock) disable iff (rst)
        clk_en && op == OP_FETCH |=> bus_addr[0] == 1'b0)
        else $error("fetch address odd");
    a_bus_upper: assert property (@(posedge clock) disable iff (rst)
        bus_addr[23:20] == {4{bus_addr[19]}})
        else $error("bus upper nibble wrong");
    a_stop_clock: assert property (@(posedge clock) disable iff (rst)
        clk_en && op == OP_STOP && ccr_reg[CC_STOP] && !clock_stopped
        |=> !clock_stopped)
        else $error("stop acted while disabled");
    a_sat_value: assert property (@(posedge clock) disable iff (rst)
        clk_en && ccr_reg[CC_SM] && ccr_reg[CC_MV]
        |=> sat_out == 16'h8000 || sat_out == 16'h7fff)
        else $error("saturation missing");
    a_zero_flag: assert property (@(posedge clock) disable iff (rst)
        clk_en && op == OP_ALU && !(reg_wr && reg_addr == OFF_CCR)
        |=> ccr_reg[CC_Z] == ($past(sum[15:0]) == 16'h0000))
        else $error("zero flag wrong");
    a_mv_sticky: assert property (@(posedge clock) disable iff (rst)
        clk_en && ccr_reg[CC_MV] && !(reg_wr && reg_addr == OFF_CCR)
        |=> ccr_reg[CC_MV])
        else $error("overflow flag lost");
    a_vec_load: assert property (@(posedge clock) disable iff (rst)
        clk_en && load_vec_reg
        |=> ptr_reg[2] == $past(rv_ptr3)
            && pbank_reg[2] == $past(rv_ptr3_bank))
        else $error("third pointer vector not loaded");
    a_irq_mask: assert property (@(posedge clock) disable iff (rst)
        clk_en && irq_level != 4'h7
        && irq_level <= {1'b0, ccr_reg[CC_IPH:CC_IPL]}
        |=> !irq_accept)
        else $error("masked interrupt accepted");
    c_push: cover property (@(posedge clock) clk_en && op == OP_PUSH);
    c_fetch: cover property (@(posedge clock) clk_en && op == OP_FETCH);
    c_vec: cover property (@(posedge clock) clk_en && load_vec_reg);
    c_stop: cover property (@(posedge clock) clock_stopped);
    c_sat:  cover property (@(posedge clock) sat_out == 16'h7fff);

endmodule

/* File: hw/crm_pkg.sv */
// Purpose: Shared constants and types for the processor register model.
// Assumes: 16-bit registers, 4-bit bank fields, 20-bit core addresses.
// Notes:   Register port offsets are local choices of this block.
package crm_pkg;

    localparam int W_REG  = 16;
    localparam int W_BANK = 4;
    localparam int W_ADDR = 20;
    localparam int W_BUS  = 24;
    localparam int W_RA   = 4;

    // Register port offsets.
    localparam logic [3:0] OFF_ACC_D   = 4'h0;
    localparam logic [3:0] OFF_ACC_E   = 4'h1;
    localparam logic [3:0] OFF_PTR1    = 4'h2;
    localparam logic [3:0] OFF_PTR2    = 4'h3;
    localparam logic [3:0] OFF_PTR3    = 4'h4;
    localparam logic [3:0] OFF_STACK   = 4'h5;
    localparam logic [3:0] OFF_PROG    = 4'h6;
    localparam logic [3:0] OFF_CCR     = 4'h7;
    localparam logic [3:0] OFF_BANKS   = 4'h8;
    localparam logic [3:0] OFF_STATUS  = 4'h9;
    localparam logic [3:0] OFF_STBANK  = 4'ha;

    // Condition code field positions.
    localparam int CC_STOP = 15;
    localparam int CC_MV   = 14;
    localparam int CC_H    = 13;
    localparam int CC_EV   = 12;
    localparam int CC_N    = 11;
    localparam int CC_Z    = 10;
    localparam int CC_V    = 9;
    localparam int CC_C    = 8;
    localparam int CC_IPH  = 7;
    localparam int CC_IPL  = 5;
    localparam int CC_SM   = 4;

    localparam logic [15:0] CCR_RESET = 16'h80e0;

    // Product accumulator bit positions.
    localparam int AM_MSB = 35;
    localparam int AM_EXT = 31;

    // Operation codes on the core operation port.
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_PUSH  = 3'b001,
        OP_PULL  = 3'b010,
        OP_FETCH = 3'b011,
        OP_ALU   = 3'b100,
        OP_BCD   = 3'b101,
        OP_MAC   = 3'b110,
        OP_STOP  = 3'b111
    } crm_op_e;

endpackage

/* File: hw/crm_if.sv */
// Purpose: Carries a 20-bit core address to the bus widener.
// Assumes: One clock domain.
// Notes:   Core drives the address; widener returns bus address.
interface crm_addr_if;
    logic [19:0] core_addr;
    logic [23:0] bus_addr;
    modport core (output core_addr, input bus_addr);
    modport widen (input core_addr, output bus_addr);
endinterface

/* File: hw/crm_bus_widen.sv */
// Purpose: Widens a 20-bit core address to the 24-bit module bus.
// Assumes: Combinational; the caller registers the result.
// Notes:   Line 19 is copied onto lines 23 to 20.
module crm_bus_widen
(
    crm_addr_if.widen a
);
    assign a.bus_addr = {{4{a.core_addr[19]}}, a.core_addr};
endmodule

/* File: test/crm_bus_model.sv */
// Purpose: Module bus side seen by the register model's widened address.
// Assumes: Bus address is registered in the core clock domain.
// Notes:   Decodes the control block and remembers any address in the hole.
module crm_bus_model
    import crm_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Address from the core.
    input  wire logic [23:0] bus_addr,
    // Decode results.
    output logic             ctrl_sel,
    output logic             gap_seen
);
    timeunit 1ns;
    timeprecision 100ps;

    // With the mapping bit kept at one the control block sits at nibble f.
    always_comb
    begin
        ctrl_sel = (bus_addr[23:20] == 4'hf) && (bus_addr[19:12] == 8'hff);
    end

    // An address between the two halves can never be decoded by any module.
    always_ff @(posedge clock)
    begin
        if (rst)
            gap_seen <= 1'b0;
        else if (bus_addr >= 24'h080000 && bus_addr <= 24'hf7ffff)
            gap_seen <= 1'b1;
    end
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the processor register model.
// Assumes: Outputs answer one cycle after the request edge.
// Notes:   Table rows cover register access; hand tests follow.
module tb
    import crm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic op_byte = 1'b0, op_sub = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] op_a = '0, op_b = '0, reg_wdata = '0, reg_rdata, sat_out, d;
    logic [3:0]  reg_addr = '0, irq_level = '0;
    logic [35:0] mac_in = '0;
    logic [23:0] bus_addr, ba;
    logic clock_stopped, irq_accept, misaligned, mis, cs, ctrl_sel, gap_seen;
    crm_op_e op = OP_NONE;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    logic [35:0] rows [7] = '{{4'h0, 16'ha55a, 16'ha55a},
        {4'h1, 16'h1234, 16'h1234}, {4'h2, 16'hbeef, 16'hbeef},
        {4'h3, 16'h0001, 16'h0001}, {4'h5, 16'h2468, 16'h2468},
        {4'h8, 16'h0521, 16'h0521}, {4'hf, 16'hffff, 16'h0000}};
    logic [35:0] alu [4] = '{{16'h7fff, 16'h0001, 4'ha},
        {16'h0005, 16'h0005, 4'h4}, {16'hffff, 16'h0001, 4'h5},
        {16'h0001, 16'h0002, 4'h9}};
    logic [43:0] fet [3] = '{{4'h8, 16'h1235, 24'hf81234},
        {4'h7, 16'hffff, 24'h07fffe}, {4'hf, 16'hfa01, 24'hfffa00}};
    logic [11:0] irq [5] = '{12'h330, 12'h341, 12'h760, 12'h771, 12'h011};

    always #4 clock = ~clock;

    crm_core_regs crm_core_regs_i (.clock(clock), .rst(rst), .clk_en(clk_en),
        .rv_ptr3(16'h7e10), .rv_ptr3_bank(4'h5), .rv_pc(16'h0200),
        .rv_sp(16'h3ffe), .rv_stack_bank(4'h0), .op(op), .op_byte(op_byte),
        .op_a(op_a), .op_b(op_b), .op_sub(op_sub), .mac_in(mac_in),
        .irq_level(irq_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_addr(bus_addr), .clock_stopped(clock_stopped),
        .irq_accept(irq_accept), .misaligned(misaligned), .sat_out(sat_out));

    crm_bus_model crm_bus_model_i (.clock(clock), .rst(rst),
        .bus_addr(bus_addr), .ctrl_sel(ctrl_sel), .gap_seen(gap_seen));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                       input string m);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clock);
    endtask

    task automatic run(input crm_op_e o, input logic b);
        op <= o;
        op_byte <= b;
        @(posedge clock);
        op <= OP_NONE;
        #1 ba = bus_addr;
        mis = misaligned;
        cs = ctrl_sel;
        @(posedge clock);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rd(OFF_CCR, d);
        chk(d, CCR_RESET, "ccr reset");
        rd(OFF_PTR3, d);
        chk(d, 16'h7e10, "third pointer vector");
        rd(OFF_BANKS, d);
        chk(d[11:8], 4'h5, "third bank vector");
        rd(OFF_STACK, d);
        chk(d, 16'h3ffe, "stack vector");
        rd(OFF_PROG, d);
        chk(d, 16'h0200, "pc vector");
        foreach (rows[i])
        begin
            wr(rows[i][35:32], rows[i][31:16]);
            rd(rows[i][35:32], d);
            chk(d, rows[i][15:0], "register row");
        end
        // Word push across a bank edge, then back.
        wr(OFF_STBANK, 16'h0004);
        wr(OFF_STACK, 16'h0000);
        run(OP_PUSH, 1'b0);
        chk(ba, 24'h040000, "push address");
        rd(OFF_STACK, d);
        chk(d, 16'hfffe, "sp after push");
        rd(OFF_STBANK, d);
        chk(d, 16'h0003, "bank after push");
        run(OP_PULL, 1'b0);
        rd(OFF_STACK, d);
        chk(d, 16'h0000, "sp after pull");
        rd(OFF_STBANK, d);
        chk(d, 16'h0004, "bank after pull");
        wr(OFF_STACK, 16'h1001);
        run(OP_PUSH, 1'b1);
        chk(mis, 1'b0, "byte push aligned");
        rd(OFF_STACK, d);
        chk(d, 16'h1000, "byte push step");
        wr(OFF_STACK, 16'h1001);
        run(OP_PUSH, 1'b0);
        chk(mis, 1'b1, "odd stack");
        run(OP_PULL, 1'b1);
        rd(OFF_STACK, d);
        chk(d, 16'h1000, "byte pull step");
        clk_en <= 1'b0;
        run(OP_PUSH, 1'b0);
        clk_en <= 1'b1;
        rd(OFF_STACK, d);
        chk(d, 16'h1000, "frozen while disabled");
        foreach (fet[i])
        begin
            wr(OFF_CCR, {12'h800, fet[i][43:40]});
            wr(OFF_PROG, fet[i][39:24]);
            run(OP_FETCH, 1'b0);
            chk(ba, fet[i][23:0], "fetch address");
        end
        chk(cs, 1'b1, "control block decode");
        foreach (alu[i])
        begin
            op_a <= alu[i][35:20];
            op_b <= alu[i][19:4];
            op_sub <= (i % 2 == 1);
            run(OP_ALU, 1'b0);
            rd(OFF_CCR, d);
            chk(d[11:8], alu[i][3:0], "nzvc");
        end
        for (int i = 0; i < 2; i++)
        begin
            op_a <= (i == 0) ? 16'h0808 : 16'h0101;
            op_b <= (i == 0) ? 16'h0808 : 16'h0101;
            op_sub <= 1'b0;
            run(OP_BCD, 1'b0);
            rd(OFF_CCR, d);
            chk(d[13], (i == 0), "half carry");
        end
        wr(OFF_CCR, 16'h8010);
        mac_in <= 36'h07fffffff;
        run(OP_MAC, 1'b0);
        mac_in <= 36'h000000001;
        run(OP_MAC, 1'b0);
        rd(OFF_CCR, d);
        chk(d[14:12], 3'b001, "extension overflow");
        mac_in <= 36'h77fffffff;
        run(OP_MAC, 1'b0);
        mac_in <= 36'h000000001;
        run(OP_MAC, 1'b0);
        rd(OFF_CCR, d);
        chk(d[14], 1'b1, "product overflow");
        chk(sat_out, 16'h7fff, "saturated value");
        foreach (irq[i])
        begin
            wr(OFF_CCR, {8'h80, irq[i][10:8], 5'h00});
            irq_level <= irq[i][7:4];
            repeat (2) @(posedge clock);
            #1 chk(irq_accept, irq[i][0], "priority mask");
            irq_level <= 4'h0;
        end
        wr(OFF_CCR, 16'h0000);
        run(OP_STOP, 1'b0);
        repeat (2) @(posedge clock);
        #1 chk(clock_stopped, 1'b1, "stop taken");
        irq_level <= 4'h1;
        repeat (3) @(posedge clock);
        #1 chk(clock_stopped, 1'b0, "wake on interrupt");
        irq_level <= 4'h0;
        wr(OFF_CCR, 16'h8000);
        run(OP_STOP, 1'b0);
        repeat (2) @(posedge clock);
        #1 chk(clock_stopped, 1'b0, "stop as no-op");
        chk(gap_seen, 1'b0, "hole never driven");
        finish_test();
    end
endmodule
